// ==== include/vstd_pkg.sv ====
// Package: offsets, fields, codes and raster figures of the standard block
package vstd_pkg;

	localparam logic [11:0] PROC_DISABLE_OFS  = 12'h000;
	localparam logic [11:0] VIDEO_STATUS_OFS  = 12'h004;
	localparam logic [15:0] PROC_DISABLE_RST  = 16'h0000;
	localparam logic [15:0] PROC_DISABLE_MASK = 16'h017F;
	localparam logic [15:0] VIDEO_STATUS_RST  = 16'h0000;

	localparam int TIMING_REF_BIT  = 0;
	localparam int LINE_NUM_BIT    = 1;
	localparam int LINE_CRC_BIT    = 2;
	localparam int ANC_CSUM_BIT    = 3;
	localparam int ERROR_PKT_BIT   = 4;
	localparam int REMAP_BIT       = 5;
	localparam int PAYLOAD_ID_BIT  = 6;
	localparam int H_STYLE_BIT     = 8;
	localparam int STD_LOCK_BIT    = 8;
	localparam int INTERLACE_BIT   = 9;
	localparam int CODE_LSB        = 10;
	localparam int CODE_MSB        = 14;

	localparam logic [4:0] CODE_720_60     = 5'h00;
	localparam logic [4:0] CODE_720_30     = 5'h02;
	localparam logic [4:0] CODE_720_50     = 5'h04;
	localparam logic [4:0] CODE_720_25     = 5'h06;
	localparam logic [4:0] CODE_720_24     = 5'h08;
	localparam logic [4:0] CODE_1080_60I   = 5'h0A;
	localparam logic [4:0] CODE_1080_30P   = 5'h0B;
	localparam logic [4:0] CODE_1080_50I   = 5'h0C;
	localparam logic [4:0] CODE_1080_25P   = 5'h0D;
	localparam logic [4:0] CODE_1080_25P_E = 5'h0E;
	localparam logic [4:0] CODE_1080_25S_E = 5'h0F;
	localparam logic [4:0] CODE_1080_24P   = 5'h10;
	localparam logic [4:0] CODE_1080_24S   = 5'h11;
	localparam logic [4:0] CODE_1080_24P_E = 5'h12;
	localparam logic [4:0] CODE_1080_24S_E = 5'h13;
	localparam logic [4:0] CODE_1250_50I   = 5'h14;
	localparam logic [4:0] CODE_1035_60I   = 5'h15;
	localparam logic [4:0] CODE_525_487    = 5'h16;
	localparam logic [4:0] CODE_525_507    = 5'h17;
	localparam logic [4:0] CODE_625        = 5'h18;
	localparam logic [4:0] CODE_525_487_G  = 5'h19;
	localparam logic [4:0] CODE_625_G      = 5'h1A;
	localparam logic [4:0] CODE_525_507_G  = 5'h1B;
	localparam logic [4:0] CODE_HD_UNKNOWN = 5'h1D;
	localparam logic [4:0] CODE_SD_UNKNOWN = 5'h1E;
	localparam logic [4:0] CODE_NONE       = 5'h00;

	localparam logic [12:0] TOT_1650 = 13'h0672;
	localparam logic [12:0] TOT_3300 = 13'h0CE4;
	localparam logic [12:0] TOT_1980 = 13'h07BC;
	localparam logic [12:0] TOT_3960 = 13'h0F78;
	localparam logic [12:0] TOT_4125 = 13'h101D;
	localparam logic [12:0] TOT_2200 = 13'h0898;
	localparam logic [12:0] TOT_2640 = 13'h0A50;
	localparam logic [12:0] TOT_2750 = 13'h0ABE;
	localparam logic [12:0] TOT_2376 = 13'h0948;
	localparam logic [12:0] TOT_1716 = 13'h06B4;
	localparam logic [12:0] TOT_1728 = 13'h06C0;
	localparam logic [12:0] ACT_1280 = 13'h0500;
	localparam logic [12:0] ACT_1440 = 13'h05A0;
	localparam logic [12:0] ACT_1920 = 13'h0780;
	localparam logic [10:0] LINES_750  = 11'h2EE;
	localparam logic [10:0] LINES_1125 = 11'h465;
	localparam logic [10:0] LINES_1250 = 11'h4E2;
	localparam logic [10:0] ALINES_1035 = 11'h40B;
	localparam logic [10:0] ALINES_507  = 11'h1FB;

	typedef struct packed {
		logic [12:0] total_samples;
		logic [12:0] active_samples;
		logic [10:0] total_lines;
		logic [10:0] active_lines;
		logic        field_scan;
		logic        sd_mode;
	} raster_t;

	typedef struct packed {
		logic [11:0] addr;
		logic        wr;
		logic        rd;
		logic [15:0] wdata;
	} host_req_t;

	typedef struct packed {
		logic h_from_trs;
		logic payload_id;
		logic remap;
		logic error_pkt;
		logic anc_csum;
		logic line_crc;
		logic line_num;
		logic timing_ref;
	} insert_en_t;

endpackage

// ==== logic/std_code_classify.sv ====
// Raster measurements to standard code and scan flag
`timescale 1ns/1ps
module std_code_classify (
	input  vstd_pkg::raster_t raster,
	output logic [4:0]        code,
	output logic              interlace
);
	logic em;

	always_comb begin
		em = raster.active_samples != vstd_pkg::ACT_1280;
		code = vstd_pkg::CODE_HD_UNKNOWN;
		interlace = raster.field_scan;
		if (raster.sd_mode) begin
			// Rate variants of one line count share one code
			if (raster.total_samples == vstd_pkg::TOT_1716) begin
				if (raster.active_lines == vstd_pkg::ALINES_507) begin
					code = (raster.active_samples == vstd_pkg::ACT_1440) ?
						vstd_pkg::CODE_525_507 :
						vstd_pkg::CODE_525_507_G;
				end else begin
					code = (raster.active_samples == vstd_pkg::ACT_1440) ?
						vstd_pkg::CODE_525_487 :
						vstd_pkg::CODE_525_487_G;
				end
			end else if (raster.total_samples == vstd_pkg::TOT_1728) begin
				code = (raster.active_samples == vstd_pkg::ACT_1440) ?
					vstd_pkg::CODE_625 : vstd_pkg::CODE_625_G;
			end else begin
				code = vstd_pkg::CODE_SD_UNKNOWN;
			end
		end else if (raster.total_lines == vstd_pkg::LINES_750) begin
			unique case (raster.total_samples)
				vstd_pkg::TOT_1650: code = vstd_pkg::CODE_720_60 | {4'h0, em};
				vstd_pkg::TOT_3300: code = vstd_pkg::CODE_720_30 | {4'h0, em};
				vstd_pkg::TOT_1980: code = vstd_pkg::CODE_720_50 | {4'h0, em};
				vstd_pkg::TOT_3960: code = vstd_pkg::CODE_720_25 | {4'h0, em};
				vstd_pkg::TOT_4125: code = vstd_pkg::CODE_720_24 | {4'h0, em};
				default:            code = vstd_pkg::CODE_HD_UNKNOWN;
			endcase
		end else if (raster.total_lines == vstd_pkg::LINES_1125) begin
			em = raster.active_samples != vstd_pkg::ACT_1920;
			if (raster.active_lines == vstd_pkg::ALINES_1035 &&
			    raster.total_samples == vstd_pkg::TOT_2200) begin
				code = vstd_pkg::CODE_1035_60I;
			end else begin
				unique case (raster.total_samples)
					vstd_pkg::TOT_2200: code = raster.field_scan ?
						vstd_pkg::CODE_1080_60I : vstd_pkg::CODE_1080_30P;
					vstd_pkg::TOT_2640: code = em ?
						(raster.field_scan ? vstd_pkg::CODE_1080_25S_E :
						vstd_pkg::CODE_1080_25P_E) :
						(raster.field_scan ? vstd_pkg::CODE_1080_50I :
						vstd_pkg::CODE_1080_25P);
					vstd_pkg::TOT_2750: code = em ?
						(raster.field_scan ? vstd_pkg::CODE_1080_24S_E :
						vstd_pkg::CODE_1080_24P_E) :
						(raster.field_scan ? vstd_pkg::CODE_1080_24S :
						vstd_pkg::CODE_1080_24P);
					default:            code = vstd_pkg::CODE_HD_UNKNOWN;
				endcase
			end
		end else if (raster.total_lines == vstd_pkg::LINES_1250 &&
		             raster.total_samples == vstd_pkg::TOT_2376) begin
			code = vstd_pkg::CODE_1250_50I;
		end
	end
endmodule

// ==== logic/video_std_proc_ctrl.sv ====
// Processing-disable register, standard status and insertion enables
//
// Contract
// - Report code 09h for 720-line extended 24 frame format, 4125 total.
// - 1080 and 1035 line formats encode as codes 0Ah through 15h.
// - 525-line inputs give 16h/17h/19h/1Bh, 625-line give 18h/1Ah.
// - 59.94 and 60 Hz variants share one code.
// - Insertions run only with bypass pin and enable pin both high.
// - Processing-disable register clears to zero at reset.
// - Bit 8 selects horizontal input style: blanking or timing bit.
// - Bit 6 low inserts payload id, needs a non-zero format byte.
// - Bit 5 low enables illegal code remapping in active picture.
// - Bit 4 low enables error-detection packets in standard definition.
// - Bit 3 low enables ancillary checksum insertion.
// - Bit 2 low enables line CRC insertion, both channels in HD.
// - Bit 1 low enables line numbers, high definition only.
// - Bit 0 low enables timing reference word insertion.
// - Standard code sits in status bits 14 to 10.
// - Code and interlace flag read zero when bypass or lock is low.
`timescale 1ns/1ps
module video_std_proc_ctrl (
	input  wire logic                 CLK,
	input  wire logic                 RESETN,
	input  vstd_pkg::host_req_t       HOST_REQ,
	output logic [15:0]               HOST_RDATA,
	input  wire logic                 CODING_BYPASS_PIN,
	input  wire logic                 PROCESSING_ENABLE_PIN,
	input  wire logic                 LOCK_INDICATOR,
	input  wire logic                 STD_LOCK,
	input  vstd_pkg::raster_t         RASTER,
	input  wire logic [31:0]          PAYLOAD_FORMAT,
	output vstd_pkg::insert_en_t      INSERT_EN,
	output logic [4:0]                STANDARD_CODE,
	output logic                      INTERLACE_FLAG
);

	typedef struct packed {
		logic [15:0]          ctrl;
		logic [15:0]          status;
		logic [15:0]          rdata;
		vstd_pkg::insert_en_t en;
	} state_t;

	state_t q;
	state_t d;

	logic [4:0] raw_code;
	logic       raw_interlace;
	logic       smpte_ok;
	logic       stream_ok;
	logic       payload_nz;
	logic       wr_ctrl;

	std_code_classify u_classify (
		.raster    (RASTER),
		.code      (raw_code),
		.interlace (raw_interlace)
	);

	// Codes come straight from the raster, so rate variants merge
	assign smpte_ok   = CODING_BYPASS_PIN && LOCK_INDICATOR;
	assign stream_ok  = CODING_BYPASS_PIN && PROCESSING_ENABLE_PIN;
	assign payload_nz = |PAYLOAD_FORMAT;
	assign wr_ctrl    = HOST_REQ.wr &&
		HOST_REQ.addr == vstd_pkg::PROC_DISABLE_OFS;

	always_comb begin
		d = q;
		if (wr_ctrl) begin
			d.ctrl = HOST_REQ.wdata & vstd_pkg::PROC_DISABLE_MASK;
		end
		d.status = vstd_pkg::VIDEO_STATUS_RST;
		d.status[vstd_pkg::STD_LOCK_BIT] = STD_LOCK;
		if (smpte_ok) begin
			d.status[vstd_pkg::CODE_MSB:vstd_pkg::CODE_LSB] = raw_code;
			d.status[vstd_pkg::INTERLACE_BIT] = raw_interlace;
		end
		if (HOST_REQ.rd) begin
			unique case (HOST_REQ.addr)
				vstd_pkg::PROC_DISABLE_OFS: d.rdata = q.ctrl;
				vstd_pkg::VIDEO_STATUS_OFS: d.rdata = q.status;
				default:                    d.rdata = 16'h0000;
			endcase
		end
		// Enables follow the register one cycle after it settles
		d.en.h_from_trs = q.ctrl[vstd_pkg::H_STYLE_BIT];
		d.en.timing_ref = stream_ok &&
			!q.ctrl[vstd_pkg::TIMING_REF_BIT];
		d.en.line_num   = stream_ok && !RASTER.sd_mode &&
			!q.ctrl[vstd_pkg::LINE_NUM_BIT];
		d.en.line_crc   = stream_ok &&
			!q.ctrl[vstd_pkg::LINE_CRC_BIT];
		d.en.anc_csum   = stream_ok &&
			!q.ctrl[vstd_pkg::ANC_CSUM_BIT];
		d.en.error_pkt  = stream_ok && RASTER.sd_mode &&
			!q.ctrl[vstd_pkg::ERROR_PKT_BIT];
		d.en.remap      = stream_ok &&
			!q.ctrl[vstd_pkg::REMAP_BIT];
		// No payload packet with all format bytes zero: nothing to carry
		d.en.payload_id = stream_ok && payload_nz &&
			!q.ctrl[vstd_pkg::PAYLOAD_ID_BIT];
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			q.ctrl   <= vstd_pkg::PROC_DISABLE_RST;
			q.status <= vstd_pkg::VIDEO_STATUS_RST;
			q.rdata  <= 16'h0000;
			q.en     <= '0;
		end else begin
			q <= d;
		end
	end

	assign HOST_RDATA     = q.rdata;
	assign INSERT_EN      = q.en;
	assign STANDARD_CODE  = q.status[vstd_pkg::CODE_MSB:vstd_pkg::CODE_LSB];
	assign INTERLACE_FLAG = q.status[vstd_pkg::INTERLACE_BIT];

	logic in_reset_seen;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			in_reset_seen <= 1'b0;
		end else begin
			in_reset_seen <= 1'b1;
		end
	end

	chk_ctrl_reset_zero: assert property (
		@(posedge CLK) !in_reset_seen |-> q.ctrl == 16'h0000)
		else $error("Control register not zero after reset");

	// Sampled reset gates the antecedents: the release edge loads nothing
	chk_ctrl_write_lands: assert property (
		@(posedge CLK) disable iff (!RESETN)
		RESETN && wr_ctrl |=>
		q.ctrl == ($past(HOST_REQ.wdata) & 16'h017F))
		else $error("Control write not stored");

	chk_unused_bits_zero: assert property (
		@(posedge CLK) disable iff (!RESETN)
		q.ctrl[15:9] == 7'h00 && q.ctrl[7] == 1'b0)
		else $error("Unused control bits not zero");

	chk_gate_pins_low: assert property (
		@(posedge CLK) disable iff (!RESETN)
		!(CODING_BYPASS_PIN && PROCESSING_ENABLE_PIN) |=>
		{q.en.payload_id, q.en.remap, q.en.error_pkt, q.en.anc_csum,
		 q.en.line_crc, q.en.line_num, q.en.timing_ref} == 7'h00)
		else $error("Insertion enabled without both pins high");

	chk_timing_ref_en: assert property (
		@(posedge CLK) disable iff (!RESETN)
		RESETN && stream_ok && !q.ctrl[0] |=> q.en.timing_ref)
		else $error("Timing reference insertion not enabled");

	chk_line_num_hd: assert property (
		@(posedge CLK) disable iff (!RESETN)
		RASTER.sd_mode |=> !q.en.line_num)
		else $error("Line numbers enabled in standard definition");

	chk_error_pkt_sd: assert property (
		@(posedge CLK) disable iff (!RESETN)
		RESETN && stream_ok && RASTER.sd_mode && !q.ctrl[4] |=>
		q.en.error_pkt)
		else $error("Error packets not enabled in standard definition");

	chk_payload_needs_byte: assert property (
		@(posedge CLK) disable iff (!RESETN)
		PAYLOAD_FORMAT == 32'h0000_0000 |=> !q.en.payload_id)
		else $error("Payload packet enabled with zero format bytes");

	chk_h_style_follows: assert property (
		@(posedge CLK) disable iff (!RESETN)
		wr_ctrl ##1 1'b1 |=> q.en.h_from_trs == $past(q.ctrl[8]))
		else $error("Horizontal style does not follow bit 8");

	chk_code_forced_zero: assert property (
		@(posedge CLK) disable iff (!RESETN)
		!(CODING_BYPASS_PIN && LOCK_INDICATOR) |=>
		STANDARD_CODE == 5'h00 && !INTERLACE_FLAG)
		else $error("Code not forced to zero without bypass or lock");

	chk_no_reserved_code: assert property (
		@(posedge CLK) disable iff (!RESETN)
		STANDARD_CODE != 5'h1C && STANDARD_CODE != 5'h1F)
		else $error("Reserved standard code reported");

	chk_code_720_24_em: assert property (
		@(posedge CLK) disable iff (!RESETN)
		RESETN && smpte_ok && !RASTER.sd_mode &&
		RASTER.total_lines == 11'h2EE &&
		RASTER.total_samples == 13'h101D &&
		RASTER.active_samples == 13'h0E10 |=> STANDARD_CODE == 5'h09)
		else $error("Extended 24 frame 720 format not coded 09h");

	chk_code_sd_625: assert property (
		@(posedge CLK) disable iff (!RESETN)
		RESETN && smpte_ok && RASTER.sd_mode &&
		RASTER.total_samples == 13'h06C0 |=>
		STANDARD_CODE == 5'h18 || STANDARD_CODE == 5'h1A)
		else $error("625-line input not coded 18h or 1Ah");

	chk_code_hd_range: assert property (
		@(posedge CLK) disable iff (!RESETN)
		RESETN && smpte_ok && !RASTER.sd_mode &&
		RASTER.total_lines == 11'h465 |=>
		STANDARD_CODE >= 5'h0A && STANDARD_CODE <= 5'h15 ||
		STANDARD_CODE == 5'h1D)
		else $error("1125-line input coded outside its range");

	chk_status_readback: assert property (
		@(posedge CLK) disable iff (!RESETN)
		HOST_REQ.rd && HOST_REQ.addr == 12'h004 |=>
		HOST_RDATA[14:10] == $past(STANDARD_CODE))
		else $error("Status read does not show standard code");

endmodule

// ==== dv/vstd_source.sv ====
// Upstream video source model: raster measurements for a chosen format
`timescale 1ns/1ps
module vstd_source (
	input  wire logic [3:0]  fmt,
	output vstd_pkg::raster_t raster
);
	// Held steady between selections, as a lock_indicator source would present them
	always_comb begin
		case (fmt)
			4'h0: raster = '{vstd_pkg::TOT_4125, 13'h0E10,
				vstd_pkg::LINES_750, 11'h2D0, 1'b0, 1'b0};
			4'h1: raster = '{vstd_pkg::TOT_2200, vstd_pkg::ACT_1920,
				vstd_pkg::LINES_1125, 11'h438, 1'b1, 1'b0};
			4'h2: raster = '{vstd_pkg::TOT_2200, vstd_pkg::ACT_1920,
				vstd_pkg::LINES_1125, 11'h438, 1'b0, 1'b0};
			4'h3: raster = '{vstd_pkg::TOT_2750, 13'h0960,
				vstd_pkg::LINES_1125, 11'h438, 1'b1, 1'b0};
			4'h4: raster = '{vstd_pkg::TOT_2200, vstd_pkg::ACT_1920,
				vstd_pkg::LINES_1125, vstd_pkg::ALINES_1035, 1'b1, 1'b0};
			4'h5: raster = '{vstd_pkg::TOT_2376, vstd_pkg::ACT_1920,
				vstd_pkg::LINES_1250, 11'h438, 1'b1, 1'b0};
			4'h6: raster = '{vstd_pkg::TOT_1716, vstd_pkg::ACT_1440,
				11'h20D, 11'h1E7, 1'b1, 1'b1};
			4'h7: raster = '{vstd_pkg::TOT_1716, vstd_pkg::ACT_1280,
				11'h20D, vstd_pkg::ALINES_507, 1'b1, 1'b1};
			4'h8: raster = '{vstd_pkg::TOT_1728, vstd_pkg::ACT_1440,
				11'h271, 11'h240, 1'b1, 1'b1};
			4'h9: raster = '{vstd_pkg::TOT_1728, vstd_pkg::ACT_1280,
				11'h271, 11'h240, 1'b1, 1'b1};
			4'hA: raster = '{13'h0100, vstd_pkg::ACT_1920,
				vstd_pkg::LINES_1125, 11'h438, 1'b0, 1'b0};
			default: raster = '{13'h0100, vstd_pkg::ACT_1440,
				11'h20D, 11'h1E7, 1'b1, 1'b1};
		endcase
	end
endmodule

// ==== dv/video_std_proc_ctrl_tb.sv ====
// Self-checking bench for the processing-disable and standard status block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module video_std_proc_ctrl_tb;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	vstd_pkg::host_req_t  req = '0;
	logic [15:0]          rdata;
	logic                 byp = 1'b1;
	logic                 pen = 1'b1;
	logic                 lck = 1'b1;
	logic                 slk = 1'b1;
	logic [3:0]           fmt = 4'h0;
	logic [31:0]          pfmt = 32'h0000_0001;
	vstd_pkg::raster_t    raster;
	vstd_pkg::insert_en_t ins;
	logic [4:0]           code;
	logic                 il;
	logic [15:0]          d;
	int                   err_total = 0;
	int                   compares = 0;
	logic [4:0] exp_code [12] = '{5'h09, 5'h0A, 5'h0B, 5'h13, 5'h15, 5'h14,
		5'h16, 5'h1B, 5'h18, 5'h1A, 5'h1D, 5'h1E};
	logic [11:0] exp_il = 12'hBFA;

	always #50 clk = ~clk;

	vstd_source src_u (.fmt(fmt), .raster(raster));
	video_std_proc_ctrl dut_u (.CLK(clk), .RESETN(rst_n), .HOST_REQ(req),
		.HOST_RDATA(rdata), .CODING_BYPASS_PIN(byp),
		.PROCESSING_ENABLE_PIN(pen), .LOCK_INDICATOR(lck), .STD_LOCK(slk),
		.RASTER(raster), .PAYLOAD_FORMAT(pfmt), .INSERT_EN(ins),
		.STANDARD_CODE(code), .INTERLACE_FLAG(il));

	task automatic wr(input logic [11:0] a, input logic [15:0] v);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [15:0] v);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	// One settle edge reaches INSERT_EN after a write; two spare for margin
	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#2_000_000;
		err_total++;
		summarize();
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(12'h000, d);
		`CHK("ctrl reset", 16'h0000, d)
		rd(12'h004, d);
		`CHK("status", 16'h2500, d)
		rd(12'h008, d);
		`CHK("unmapped", 16'h0000, d)
		settle();
		`CHK("ins reset", 8'h6F, ins)
		$display("test reset done");
		for (int b = 0; b < 9; b++) begin
			if (b == 7)
				continue;
			wr(12'h000, 16'h0001 << b);
			settle();
			rd(12'h000, d);
			`CHK("ctrl bit", 16'h0001 << b, d)
			`CHK("ins bit", (b == 8) ? 8'hEF : (8'h6F & ~(8'h01 << b)), ins)
		end
		wr(12'h000, 16'hFFFF);
		wr(12'h004, 16'hFFFF);
		settle();
		rd(12'h000, d);
		`CHK("ctrl mask", 16'h017F, d)
		`CHK("ins all off", 8'h80, ins)
		$display("test bits done");
		wr(12'h000, 16'h0000);
		fmt <= 4'h6;
		settle();
		`CHK("ins sd", 8'h7D, ins)
		@(posedge clk);
		pfmt <= 32'h0000_0000;
		settle();
		`CHK("ins no payload", 8'h3D, ins)
		@(posedge clk);
		pfmt <= 32'h8000_0000;
		pen <= 1'b0;
		settle();
		`CHK("ins pen low", 8'h00, ins)
		@(posedge clk);
		pen <= 1'b1;
		byp <= 1'b0;
		settle();
		`CHK("ins byp low", 8'h00, ins)
		`CHK("code byp low", 5'h00, code)
		`CHK("il byp low", 1'b0, il)
		@(posedge clk);
		byp <= 1'b1;
		lck <= 1'b0;
		settle();
		`CHK("code lock low", 5'h00, code)
		`CHK("il lock low", 1'b0, il)
		@(posedge clk);
		lck <= 1'b1;
		$display("test pins done");
		// Same raster for 59.94 and 60 Hz sources, so one code each
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			fmt <= i[3:0];
			slk <= i[0];
			settle();
			`CHK("code", exp_code[i], code)
			`CHK("il", exp_il[i], il)
			rd(12'h004, d);
			`CHK("status", {1'b0, exp_code[i], exp_il[i], i[0], 8'h00}, d)
		end
		$display("test codes done");
		wr(12'h000, 16'h0105);
		rd(12'h000, d);
		`CHK("ctrl before reset", 16'h0105, d)
		@(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		`CHK("ins in reset", 8'h00, ins)
		@(posedge clk);
		rst_n <= 1'b1;
		rd(12'h000, d);
		`CHK("ctrl re-reset", 16'h0000, d)
		$display("test rereset done");
		summarize();
	end
endmodule
